// ==== logic/vpiu_edge.sv ====
module vpiu_edge
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // Pin and edge choice
  input  wire logic i_pin,
  input  wire logic i_rise_sel,
  // Detected edge
  output logic      o_pulse
);

  vpiu_pkg::vpiu_edge_state_t r;
  vpiu_pkg::vpiu_edge_state_t next_r;

  always_comb
  begin
    next_r       = r;
    next_r.s1    = i_pin;
    next_r.s2    = r.s1;
    next_r.s3    = r.s2;
    // Edge seen only past the second stage, never on the first flop
    next_r.pulse = i_rise_sel ? (r.s2 & ~r.s3) : (~r.s2 & r.s3);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, pulse: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_pulse = r.pulse;

endmodule

// ==== logic/vpiu_pkg.sv ====
package vpiu_pkg;

  // Register indices on the local register port
  localparam logic [2:0] REG_PENDING   = 3'h0;
  localparam logic [2:0] REG_MASK      = 3'h1;
  localparam logic [2:0] REG_PRIORITY  = 3'h2;
  localparam logic [2:0] REG_EDGE      = 3'h3;
  localparam logic [2:0] REG_EVT_STAT  = 3'h4;
  localparam logic [2:0] REG_EVT_MASK  = 3'h5;
  localparam logic [2:0] REG_SEQ_STAT  = 3'h6;

  // Field positions
  localparam int MASK_GIE_BIT   = 7;
  localparam int PRIO_REV_BIT   = 3;
  localparam int EVT_GRANT_BIT  = 0;
  localparam int EVT_VECTOR_BIT = 1;
  localparam int EVT_OVERRUN_BIT = 2;

  // Values after reset
  localparam logic [5:0] PENDING_RST  = 6'h00;
  localparam logic [5:0] ENABLE_RST   = 6'h00;
  localparam logic       GIE_RST      = 1'b0;
  localparam logic [3:0] PRIORITY_RST = 4'h0;
  localparam logic [1:0] EDGE_RST     = 2'h0;
  localparam logic [2:0] EVT_RST      = 3'h0;

  // Grant timing, in input clock periods, and clock periods in ns
  localparam int TPC_NS         = 20;
  localparam int CLK_NS         = 20;
  localparam int REQ_SETUP_TPC  = 5;
  localparam int STACK_TPC      = 48;
  localparam int VECTOR_TPC     = 9;
  localparam int PUSH_PCL_TPC   = 16;
  localparam int PUSH_PCH_TPC   = 32;
  localparam int VEC_LAT_TPC    = 4;
  localparam logic [5:0] STACK_CYC  = 6'(STACK_TPC * TPC_NS / CLK_NS);
  localparam logic [5:0] VECTOR_CYC = 6'(VECTOR_TPC * TPC_NS / CLK_NS);
  localparam logic [5:0] PUSH_PCL_CYC = 6'(PUSH_PCL_TPC * TPC_NS / CLK_NS);
  localparam logic [5:0] PUSH_PCH_CYC = 6'(PUSH_PCH_TPC * TPC_NS / CLK_NS);
  localparam logic [5:0] VEC_LAT_CYC  = 6'(VEC_LAT_TPC * TPC_NS / CLK_NS);
  localparam logic [5:0] VEC_HI_CYC   = STACK_CYC + 6'h01;
  localparam logic [5:0] VEC_LO_CYC   = VEC_HI_CYC + VEC_LAT_CYC;
  localparam logic [5:0] VEC_END_CYC  = STACK_CYC + VECTOR_CYC;
  localparam logic [5:0] FETCH_CYC    = VEC_END_CYC + 6'h01;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_STACK  = 4'b0010,
    ST_VECTOR = 4'b0100,
    ST_BRANCH = 4'b1000
  } vpiu_seq_t;

  // On-chip request sources, one-cycle pulses on the system clock
  typedef struct packed {
    logic port0_handshake_strobe;
    logic port2_handshake_strobe;
    logic timer_input;
    logic timer_zero;
    logic timer_one;
    logic timer_two;
    logic serial_rx;
    logic serial_tx;
  } vpiu_src_t;

  // Stack strobes toward the core
  typedef struct packed {
    logic push_pc_low;
    logic push_pc_high;
    logic push_flags;
  } vpiu_stack_t;

  typedef struct packed {
    logic [5:0]  pend;
    logic        gie;
    logic [5:0]  ien;
    logic [3:0]  prio;
    logic [1:0]  edge_rise;
    logic [2:0]  evt;
    logic [2:0]  evt_mask;
    vpiu_seq_t   st;
    logic [5:0]  cnt;
    logic [2:0]  line;
    logic [15:0] vec_addr;
    logic [15:0] vec;
    logic [7:0]  rdata;
  } vpiu_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } vpiu_edge_state_t;

endpackage

// ==== logic/vpiu_prio.sv ====
module vpiu_prio
(
  // Candidate requests
  input  wire logic [5:0] i_req,
  // Order control
  input  wire logic [2:0] i_first,
  input  wire logic       i_reverse,
  // Winner
  output logic            o_any,
  output logic [2:0]      o_line
);

  // Circular order starting at i_first; lowest step wins
  always_comb
  begin
    int b;
    int p;
    b      = int'(i_first) % 6;
    p      = 0;
    o_any  = 1'b0;
    o_line = 3'h0;
    for (int k = 5; k >= 0; k--)
    begin
      p = i_reverse ? (b + 6 - k) % 6 : (b + k) % 6;
      if (i_req[p])
      begin
        o_any  = 1'b1;
        o_line = 3'(p);
      end
    end
  end

endmodule

// ==== logic/vpiu_top.sv ====
// Summary of operation
// - Six request lines from twelve sources, each maskable and prioritised.
// - Sources: four port-3 pins, port 0 and port 2 handshake strobes, serial receive, serial transmit, four timer sources.
// - Mask register has a global enable and one enable bit per line.
// - Priority register steers the encoder choosing among several enabled requests.
// - Grant clears global enable, saves program counter and flags, then vectors.
// - Vector is two consecutive bytes forming a 16-bit routine address.
// - Masked lines still latch requests so software can poll pending bits.
// - Software writing one to a pending bit acts as a hardware request.
// - Requests sampled at last instruction cycle; need five clock periods of setup.
// - Forty-eight cycles after sample resolve priority and push PC and flags.
// - Next nine cycles fetch both vector bytes from program memory.
// - First routine byte fetch begins on the 58th cycle after sampling.
// - Line-to-source map and vector pair locations 0,1 through 10,11.
// - Pins 1 and 2 have selectable edge; pins 0 and 3 falling only.
// - Timer zero and timer one end of count request lines 4 and 5.
//
// The placing of the registers and the plain strobed port were decided locally.
module vpiu_top
(
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  // Register port
  input  wire logic [2:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic [7:0]                o_rdata,
  // Request sources
  input  wire logic [3:0]           i_port3_pin,
  input  wire vpiu_pkg::vpiu_src_t  i_src,
  // Core sequencer
  input  wire logic                 i_instr_last,
  output logic                      o_busy,
  output vpiu_pkg::vpiu_stack_t     o_stack,
  output logic                      o_vec_rd,
  output logic [15:0]               o_vec_addr,
  input  wire logic [7:0]           i_pmem_data,
  output logic                      o_fetch_start,
  output logic [15:0]               o_vector,
  // Event interrupt
  output logic                      o_irq
);

  vpiu_pkg::vpiu_state_t r;
  vpiu_pkg::vpiu_state_t next_r;

  logic [3:0] pin_edge;
  logic [3:0] rise_sel;
  logic [5:0] hw_req;
  logic [5:0] eligible;
  logic       win_any;
  logic [2:0] win_line;
  logic       grant;
  logic [2:0] evt_set;
  logic [7:0] rd_mux;

  assign rise_sel = {1'b0, r.edge_rise[1], r.edge_rise[0], 1'b0};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      // pins pass two flops before use
      vpiu_edge u_edge
      (
        .i_clk_sys  (i_clk_sys),
        .i_reset    (i_reset),
        .i_pin      (i_port3_pin[g]),
        .i_rise_sel (rise_sel[g]),
        .o_pulse    (pin_edge[g])
      );
    end
  endgenerate

  always_comb
  begin
    hw_req[0] = i_src.port0_handshake_strobe | pin_edge[2] | i_src.timer_two;
    hw_req[1] = pin_edge[3];
    hw_req[2] = i_src.port2_handshake_strobe | pin_edge[1] | i_src.timer_input;
    hw_req[3] = pin_edge[0] | i_src.serial_rx;
    hw_req[4] = i_src.timer_zero | i_src.serial_tx;
    hw_req[5] = i_src.timer_one;
  end

  // only enabled lines under global enable
  assign eligible = r.pend & r.ien & {6{r.gie}};

  vpiu_prio u_prio
  (
    .i_req     (eligible),
    .i_first   (r.prio[2:0]),
    .i_reverse (r.prio[vpiu_pkg::PRIO_REV_BIT]),
    .o_any     (win_any),
    .o_line    (win_line)
  );

  assign grant = (r.st == vpiu_pkg::ST_IDLE) && i_instr_last && win_any;

  always_comb
  begin
    rd_mux = 8'h00;
    case (i_addr)
      vpiu_pkg::REG_PENDING:  rd_mux = {2'b00, r.pend};
      vpiu_pkg::REG_MASK:     rd_mux = {r.gie, 1'b0, r.ien};
      vpiu_pkg::REG_PRIORITY: rd_mux = {4'h0, r.prio};
      vpiu_pkg::REG_EDGE:     rd_mux = {6'h00, r.edge_rise};
      vpiu_pkg::REG_EVT_STAT: rd_mux = {5'h00, r.evt};
      vpiu_pkg::REG_EVT_MASK: rd_mux = {5'h00, r.evt_mask};
      vpiu_pkg::REG_SEQ_STAT: rd_mux = {(r.st != vpiu_pkg::ST_IDLE), 4'h0, r.line};
      default:                rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    evt_set = 3'h0;
    evt_set[vpiu_pkg::EVT_GRANT_BIT]   = grant;
    evt_set[vpiu_pkg::EVT_VECTOR_BIT]  = (r.st == vpiu_pkg::ST_BRANCH);
    // A request landing on a line that is already pending is merged
    evt_set[vpiu_pkg::EVT_OVERRUN_BIT] = |(hw_req & r.pend);
  end

  always_comb
  begin
    next_r       = r;
    next_r.rdata = i_rd ? rd_mux : 8'h00;

    // Software writes
    if (i_wr)
    begin
      case (i_addr)
        vpiu_pkg::REG_PENDING:
        begin
          // software write of one behaves as a request; a written zero clears the bit
          next_r.pend = i_wdata[5:0];
        end
        vpiu_pkg::REG_MASK:
        begin
          next_r.gie = i_wdata[vpiu_pkg::MASK_GIE_BIT];
          next_r.ien = i_wdata[5:0];
        end
        vpiu_pkg::REG_PRIORITY: next_r.prio = i_wdata[3:0];
        vpiu_pkg::REG_EDGE:     next_r.edge_rise = i_wdata[1:0];
        vpiu_pkg::REG_EVT_STAT: next_r.evt = r.evt & ~i_wdata[2:0];
        vpiu_pkg::REG_EVT_MASK: next_r.evt_mask = i_wdata[2:0];
        default:                next_r.rdata = next_r.rdata;
      endcase
    end

    // Set wins over a clear in the same cycle
    next_r.evt = next_r.evt | evt_set;

    case (r.st)
      vpiu_pkg::ST_IDLE:
      begin
        if (grant)
        begin
          next_r.gie = 1'b0;
          // grant clears the serviced pending bit
          next_r.pend[win_line] = 1'b0;
          next_r.line = win_line;
          next_r.cnt = 6'h01;
          // vector pair at twice the line number
          next_r.vec_addr = {12'h000, win_line, 1'b0};
          next_r.st = vpiu_pkg::ST_STACK;
        end
      end
      vpiu_pkg::ST_STACK:
      begin
        next_r.cnt = r.cnt + 6'h01;
        if (r.cnt == vpiu_pkg::STACK_CYC)
        begin
          next_r.st = vpiu_pkg::ST_VECTOR;
        end
      end
      vpiu_pkg::ST_VECTOR:
      begin
        next_r.cnt = r.cnt + 6'h01;
        if (r.cnt == vpiu_pkg::VEC_LO_CYC - 6'h01)
        begin
          next_r.vec_addr = r.vec_addr + 16'h0001;
        end
        // high byte first, then low byte
        if (r.cnt == vpiu_pkg::VEC_LO_CYC)
        begin
          next_r.vec[15:8] = i_pmem_data;
        end
        if (r.cnt == vpiu_pkg::VEC_END_CYC)
        begin
          next_r.vec[7:0] = i_pmem_data;
          next_r.st = vpiu_pkg::ST_BRANCH;
        end
      end
      vpiu_pkg::ST_BRANCH:
      begin
        next_r.cnt = 6'h00;
        next_r.st = vpiu_pkg::ST_IDLE;
      end
      default:
      begin
        next_r.cnt = 6'h00;
        next_r.st = vpiu_pkg::ST_IDLE;
      end
    endcase

    next_r.pend = next_r.pend | hw_req;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      r.pend      <= vpiu_pkg::PENDING_RST;
      r.gie       <= vpiu_pkg::GIE_RST;
      r.ien       <= vpiu_pkg::ENABLE_RST;
      r.prio      <= vpiu_pkg::PRIORITY_RST;
      r.edge_rise <= vpiu_pkg::EDGE_RST;
      r.evt       <= vpiu_pkg::EVT_RST;
      r.evt_mask  <= vpiu_pkg::EVT_RST;
      r.st        <= vpiu_pkg::ST_IDLE;
      r.cnt       <= 6'h00;
      r.line      <= 3'h0;
      r.vec_addr  <= 16'h0000;
      r.vec       <= 16'h0000;
      r.rdata     <= 8'h00;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_rdata    = r.rdata;
  assign o_busy     = (r.st != vpiu_pkg::ST_IDLE);
  assign o_vec_addr = r.vec_addr;
  assign o_vector   = r.vec;
  assign o_irq      = |(r.evt & r.evt_mask);

  // save PC bytes and flags during stacking
  assign o_stack.push_pc_low  = (r.st == vpiu_pkg::ST_STACK) &&
                                (r.cnt == vpiu_pkg::PUSH_PCL_CYC);
  assign o_stack.push_pc_high = (r.st == vpiu_pkg::ST_STACK) &&
                                (r.cnt == vpiu_pkg::PUSH_PCH_CYC);
  assign o_stack.push_flags   = (r.st == vpiu_pkg::ST_STACK) &&
                                (r.cnt == vpiu_pkg::STACK_CYC);

  assign o_vec_rd = (r.st == vpiu_pkg::ST_VECTOR) &&
                    ((r.cnt == vpiu_pkg::VEC_HI_CYC) || (r.cnt == vpiu_pkg::VEC_LO_CYC));

  assign o_fetch_start = (r.st == vpiu_pkg::ST_BRANCH) && (r.cnt == vpiu_pkg::FETCH_CYC);

endmodule

// ==== verif/vpiu_assertions.sv ====
module vpiu_assertions
(
  input wire logic                  i_clk_sys,
  input wire logic                  i_reset,
  input wire logic                  i_rd,
  input wire logic                  i_instr_last,
  input wire logic [7:0]            o_rdata,
  input wire logic                  o_busy,
  input wire vpiu_pkg::vpiu_stack_t o_stack,
  input wire logic                  o_vec_rd,
  input wire logic [15:0]           o_vec_addr,
  input wire logic                  o_fetch_start,
  input wire logic [15:0]           o_vector
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_grant_cause: assert property ($rose(o_busy) |-> $past(i_instr_last))
    else $error("grant without sample point");
  a_stack_timeline: assert property ($rose(o_busy) |-> ##15 o_stack.push_pc_low
    ##16 o_stack.push_pc_high ##16 o_stack.push_flags) else $error("stack push timing");
  a_vector_reads: assert property ($rose(o_busy) |-> ##48 (o_vec_rd && !o_vec_addr[0])
    ##4 (o_vec_rd && o_vec_addr[0])) else $error("vector read timing");
  a_fetch_begin: assert property ($rose(o_busy) |-> ##57 o_fetch_start ##1 !o_busy)
    else $error("routine fetch timing");
  a_vec_range: assert property (o_vec_rd |-> o_vec_addr <= 16'h000b)
    else $error("vector address out of range");
  a_vec_pair: assert property (o_vec_rd && o_vec_addr[0] |->
    $past(o_vec_addr, 4) == {o_vec_addr[15:1], 1'b0}) else $error("vector pair split");
  a_strobe_single: assert property ($onehot0({o_stack, o_vec_rd, o_fetch_start}))
    else $error("overlapping sequence strobes");
  a_vector_hold: assert property (!o_busy && !$past(o_busy) |-> $stable(o_vector))
    else $error("vector moved while idle");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule
bind vpiu_top vpiu_assertions vpiu_assertions_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_rd(i_rd), .i_instr_last(i_instr_last), .o_rdata(o_rdata), .o_busy(o_busy),
  .o_stack(o_stack), .o_vec_rd(o_vec_rd), .o_vec_addr(o_vec_addr),
  .o_fetch_start(o_fetch_start), .o_vector(o_vector));

// ==== verif/vpiu_core_model.sv ====
module vpiu_core_model
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // Vector reads from the unit
  input  wire logic        i_vec_rd,
  input  wire logic [15:0] i_vec_addr,
  // Sequencer and program memory
  output logic             o_instr_last,
  output logic [7:0]       o_pmem_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  logic [2:0] hold;
  assign o_instr_last = (phase == 2'h3);
  always @(posedge i_clk_sys)
  begin
    phase <= i_reset ? 2'h0 : phase + 2'h1;
    if (i_reset)
      hold <= 3'h0;
    else if (i_vec_rd)
    begin
      o_pmem_data <= 8'h3c ^ (i_vec_addr[7:0] * 8'h07);
      hold        <= 3'h4;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
    else
      o_pmem_data <= ~o_pmem_data;
  end
  initial o_pmem_data = 8'h00;
endmodule

// ==== verif/vpiu_top_bench.sv ====
module vpiu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_clk_sys = 1'b0;
  logic                  i_reset = 1'b1;
  logic [2:0]            i_addr = 3'h0;
  logic [7:0]            i_wdata = 8'h00;
  logic                  i_wr = 1'b0;
  logic                  i_rd = 1'b0;
  logic [7:0]            o_rdata;
  logic [3:0]            i_port3_pin = 4'hf;
  vpiu_pkg::vpiu_src_t   i_src = '0;
  logic                  i_instr_last;
  logic                  o_busy;
  vpiu_pkg::vpiu_stack_t o_stack;
  logic                  o_vec_rd;
  logic [15:0]           o_vec_addr;
  logic [7:0]            i_pmem_data;
  logic                  o_fetch_start;
  logic [15:0]           o_vector;
  logic                  o_irq;
  int                    err_total = 0;
  int                    total_checks = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  vpiu_top vpiu_top_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port3_pin(i_port3_pin),
    .i_src(i_src), .i_instr_last(i_instr_last), .o_busy(o_busy), .o_stack(o_stack),
    .o_vec_rd(o_vec_rd), .o_vec_addr(o_vec_addr), .i_pmem_data(i_pmem_data),
    .o_fetch_start(o_fetch_start), .o_vector(o_vector), .o_irq(o_irq));
  vpiu_core_model vpiu_core_model_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_vec_rd(o_vec_rd), .i_vec_addr(o_vec_addr), .o_instr_last(i_instr_last),
    .o_pmem_data(i_pmem_data));
  task conclude();
    $display("mismatches %0d comparisons %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    d = o_rdata;
  endtask
  function automatic int winner(logic [5:0] r, logic [3:0] p);
    int f = p[2:0] % 6;
    for (int k = 0; k < 6; k++)
      if (r[p[3] ? (f - k + 6) % 6 : (f + k) % 6]) return p[3] ? (f - k + 6) % 6 : (f + k) % 6;
    return 0;
  endfunction
  // Line fed by each source bit, lsb first
  int lt[8] = '{4, 3, 0, 5, 4, 2, 2, 0};
  int pl[4] = '{3, 2, 0, 1};
  logic [7:0] d;
  logic [5:0] r;
  logic [5:0] m;
  logic [3:0] pr;
  logic [1:0] e;
  int w, n;
  logic hf, hr;
  initial
  begin
    void'($urandom(38392));
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    for (int j = 0; j < 8; j++)
    begin
      @(posedge i_clk_sys) i_src <= vpiu_pkg::vpiu_src_t'(8'h01 << j);
      @(posedge i_clk_sys) i_src <= '0;
      repeat (3) @(posedge i_clk_sys);
      rd(3'h0, d);
      chk("pending from source", 16'(1 << lt[j]), {8'h00, d});
      // A second request on a line still pending is merged and flagged
      @(posedge i_clk_sys) i_src <= vpiu_pkg::vpiu_src_t'(8'h01 << j);
      @(posedge i_clk_sys) i_src <= '0;
      @(posedge i_clk_sys);
      rd(3'h4, d);
      chk("overrun event", 16'h0004, {8'h00, d});
      wr(3'h4, 8'h07);
      wr(3'h0, 8'h00);
    end
    for (int p = 0; p < 4; p++)
    begin
      e = 2'($urandom);
      wr(3'h3, {6'h00, e});
      hr = (p == 1 && e[0]) || (p == 2 && e[1]);
      hf = !hr;
      @(posedge i_clk_sys) i_port3_pin[p] <= 1'b0;
      repeat (6) @(posedge i_clk_sys);
      rd(3'h0, d);
      chk("pin falling", hf ? 16'(1 << pl[p]) : 16'h0000, {8'h00, d});
      wr(3'h0, 8'h00);
      @(posedge i_clk_sys) i_port3_pin[p] <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      rd(3'h0, d);
      chk("pin rising", hr ? 16'(1 << pl[p]) : 16'h0000, {8'h00, d});
      wr(3'h0, 8'h00);
    end
    for (int k = 0; k < 6; k++)
    begin
      r = (k == 0) ? 6'h3f : 6'($urandom % 63 + 1);
      // Keep at least one pending line enabled so a grant must follow
      m = (k == 0) ? 6'h3f : 6'($urandom) | (r & (~r + 6'h01));
      pr = 4'($urandom);
      wr(3'h1, {2'b00, m});
      wr(3'h0, {2'h0, r});
      wr(3'h2, {4'h0, pr});
      repeat (8) @(posedge i_clk_sys);
      chk("busy while masked", 16'h0000, {15'h0, o_busy});
      wr(3'h5, 8'h01);
      wr(3'h1, {2'b10, m});
      for (n = 0; n < 200; n++)
      begin
        @(negedge i_clk_sys);
        if (o_fetch_start === 1'b1) break;
      end
      if (n == 200)
      begin
        chk("grant timeout", 16'h0001, 16'h0000);
        break;
      end
      w = winner(r & m, pr);
      chk("vector", {8'h3c ^ 8'(w * 14), 8'h3c ^ 8'((2 * w + 1) * 7)}, o_vector);
      repeat (3) @(posedge i_clk_sys);
      chk("event irq", 16'h0001, {15'h0, o_irq});
      rd(3'h6, d);
      chk("granted line", 16'(w), {13'h0, d[2:0]});
      rd(3'h0, d);
      chk("pending after grant", {10'h0, r & ~6'(1 << w)}, {8'h00, d});
      rd(3'h1, d);
      chk("global enable cleared", {10'h0, m}, {8'h00, d});
      rd(3'h4, d);
      chk("event status", 16'h0003, {8'h00, d});
      wr(3'h4, 8'h07);
      @(negedge i_clk_sys);
      chk("irq cleared", 16'h0000, {15'h0, o_irq});
    end
    conclude();
  end
endmodule
